// file: lcd_common_segment_sequencer.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// RL1: commons active in turn, one per slice
// RL2: static mode drives all commons alike
// RL3: segment data from 28-word display memory
// RL4: slice k reads bit k of each byte
// RL5: bit one selects, bit zero deselects segment
// RL6: unfetched bits stay plain storage
// RL7: upper four memory bits read zero
// RL8: top twelve segments shareable with ports
// RL9: alternate polarity, no net DC
// RL10: full voltage only when both selected
// RL11: levels follow static, half, third bias
// RL12: one slice per divided clock period
// RL13: three-bit mode field, other codes refused
// RL14: display off deselects every segment
// RL15: port selector bit per shared pin pair
// RL16: slice clock from selectable divided source
// RL17: polarity flips at each frame end
module lcd_common_segment_sequencer #(
   parameter int NUM_SEG = 28
) (
   // clock and control
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // apb slave
   input wire lcd_seq_pkg::apb_req_t apb_req_in,
   output lcd_seq_pkg::apb_rsp_t apb_rsp_out,
   // subsystem clock pin
   input wire logic sub_clk_in,
   // panel drive level selections
   output logic [3:0][1:0] common_drive_out,
   output logic [NUM_SEG-1:0][1:0] seg_drive_out,
   output logic [NUM_SEG-1:0] seg_enable_out
);
   if (NUM_SEG <= lcd_seq_pkg::SHARED_FIRST ||
       NUM_SEG > int'(lcd_seq_pkg::MEM_LAST_IDX - lcd_seq_pkg::MEM_FIRST_IDX) + 1) begin : g_bad_num_seg
      $error("NUM_SEG out of supported range");
   end

   logic display_on_bit_ff;
   logic [2:0] display_mode_reg_ff;
   logic [5:0] port_segment_selector_ff;
   logic [3:0] slice_clock_config_reg_ff;
   logic [NUM_SEG-1:0][3:0] mem_ff;
   logic [1:0] slice_ff;
   logic pol_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic lcd_slice_clock_tick;
   logic setup;
   logic wr_en;
   lcd_seq_pkg::sel_t sel;
   logic [4:0] widx;
   logic [1:0] last;
   lcd_seq_pkg::bias_t bias;
   logic [31:0] nxt_prdata;
   logic [3:0][1:0] nxt_com;
   logic [NUM_SEG-1:0][1:0] nxt_seg;

   function automatic lcd_seq_pkg::sel_t reg_sel(input logic [17:0] a);
      logic [15:0] off;
      off = a[17:2] - lcd_seq_pkg::MEM_FIRST_IDX;
      if (a == lcd_seq_pkg::MODE_OFS) begin
         reg_sel = lcd_seq_pkg::SEL_MODE;
      end else if (a == lcd_seq_pkg::PORTSEL_OFS) begin
         reg_sel = lcd_seq_pkg::SEL_PORTSEL;
      end else if (a == lcd_seq_pkg::CLKCFG_OFS) begin
         reg_sel = lcd_seq_pkg::SEL_CLKCFG;
      end else if (a == lcd_seq_pkg::STATUS_OFS) begin
         reg_sel = lcd_seq_pkg::SEL_STATUS;
      end else if (a[1:0] == 2'h0 && a[17:2] >= lcd_seq_pkg::MEM_FIRST_IDX && off < 16'(NUM_SEG)) begin
         reg_sel = lcd_seq_pkg::SEL_MEM;
      end else begin
         reg_sel = lcd_seq_pkg::SEL_NONE;
      end
   endfunction

   function automatic logic mode_legal(input logic [2:0] m);
      mode_legal = (m <= lcd_seq_pkg::MODE_STATIC);
   endfunction

   function automatic logic [1:0] drive_level(input logic is_com, input logic sel_lvl, input logic pol,
                                              input lcd_seq_pkg::bias_t b);
      logic [1:0] sel_com;
      logic [1:0] sel_seg;
      sel_com = pol ? lcd_seq_pkg::LVL_GROUND : lcd_seq_pkg::LVL_TOP;
      sel_seg = pol ? lcd_seq_pkg::LVL_TOP : lcd_seq_pkg::LVL_GROUND;
      if (sel_lvl) begin
         drive_level = is_com ? sel_com : sel_seg; // [RL10] [RL9]
      end else if (b == lcd_seq_pkg::BIAS_THIRD) begin
         if (is_com) begin
            drive_level = pol ? lcd_seq_pkg::LVL_UPPER_MID : lcd_seq_pkg::LVL_LOWER_MID; // [RL11]
         end else begin
            drive_level = pol ? lcd_seq_pkg::LVL_LOWER_MID : lcd_seq_pkg::LVL_UPPER_MID; // [RL11]
         end
      end else if (b == lcd_seq_pkg::BIAS_HALF && is_com) begin
         drive_level = lcd_seq_pkg::LVL_UPPER_MID; // [RL11]
      end else begin
         drive_level = sel_com; // [RL11]
      end
   endfunction

   lcd_slice_clock_gen u_clk_gen (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .src_sel_in(slice_clock_config_reg_ff[3:2]),
      .div_sel_in(slice_clock_config_reg_ff[1:0]),
      .sub_clk_in(sub_clk_in),
      .slice_tick_out(lcd_slice_clock_tick) // [RL16]
   );

   // bus decode
   assign setup = apb_req_in.psel && !apb_req_in.penable;
   assign wr_en = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
   assign sel = reg_sel(apb_req_in.paddr);
   assign widx = 5'(apb_req_in.paddr[17:2] - lcd_seq_pkg::MEM_FIRST_IDX);
   assign apb_rsp_out.pready = 1'b1;
   assign apb_rsp_out.pslverr = pslverr_ff;
   assign apb_rsp_out.prdata = prdata_ff;

   always_comb begin
      nxt_prdata = 32'h00000000;
      if (sel == lcd_seq_pkg::SEL_MODE) begin
         nxt_prdata[lcd_seq_pkg::DISP_ON_POS] = display_on_bit_ff;
         nxt_prdata[2:0] = display_mode_reg_ff;
      end else if (sel == lcd_seq_pkg::SEL_PORTSEL) begin
         nxt_prdata[5:0] = port_segment_selector_ff;
      end else if (sel == lcd_seq_pkg::SEL_CLKCFG) begin
         nxt_prdata[3:0] = slice_clock_config_reg_ff;
      end else if (sel == lcd_seq_pkg::SEL_STATUS) begin
         nxt_prdata[lcd_seq_pkg::STAT_POL_POS] = pol_ff;
         nxt_prdata[1:0] = slice_ff;
      end else if (sel == lcd_seq_pkg::SEL_MEM) begin
         nxt_prdata[3:0] = mem_ff[widx]; // [RL7] [RL6]
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else if (ce_in && setup) begin
         prdata_ff <= apb_req_in.pwrite ? 32'h00000000 : nxt_prdata;
         pslverr_ff <= (sel == lcd_seq_pkg::SEL_NONE);
      end
   end

   // control registers
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         display_on_bit_ff <= 1'b0;
         display_mode_reg_ff <= lcd_seq_pkg::MODE_RST;
         port_segment_selector_ff <= lcd_seq_pkg::PORTSEL_RST;
         slice_clock_config_reg_ff <= lcd_seq_pkg::CLKCFG_RST;
      end else if (ce_in && wr_en) begin
         if (sel == lcd_seq_pkg::SEL_MODE) begin
            display_on_bit_ff <= apb_req_in.pwdata[lcd_seq_pkg::DISP_ON_POS];
            if (mode_legal(apb_req_in.pwdata[2:0])) begin
               display_mode_reg_ff <= apb_req_in.pwdata[2:0]; // [RL13]
            end
         end else if (sel == lcd_seq_pkg::SEL_PORTSEL) begin
            port_segment_selector_ff <= apb_req_in.pwdata[5:0]; // [RL15]
         end else if (sel == lcd_seq_pkg::SEL_CLKCFG) begin
            slice_clock_config_reg_ff <= apb_req_in.pwdata[3:0]; // [RL16]
         end
      end
   end

   // display memory, only the low nibble is stored
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         mem_ff <= '0;
      end else if (ce_in && wr_en && sel == lcd_seq_pkg::SEL_MEM) begin
         mem_ff[widx] <= apb_req_in.pwdata[3:0]; // [RL3] [RL7]
      end
   end

   // slice count and bias from mode
   always_comb begin
      case (display_mode_reg_ff)
         lcd_seq_pkg::MODE_4S_THIRD: begin
            last = 2'h3;
            bias = lcd_seq_pkg::BIAS_THIRD;
         end
         lcd_seq_pkg::MODE_3S_THIRD: begin
            last = 2'h2;
            bias = lcd_seq_pkg::BIAS_THIRD;
         end
         lcd_seq_pkg::MODE_2S_HALF: begin
            last = 2'h1;
            bias = lcd_seq_pkg::BIAS_HALF;
         end
         lcd_seq_pkg::MODE_3S_HALF: begin
            last = 2'h2;
            bias = lcd_seq_pkg::BIAS_HALF;
         end
         default: begin
            last = 2'h0;
            bias = lcd_seq_pkg::BIAS_STATIC;
         end
      endcase
   end

   // slice sequencing and frame polarity
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         slice_ff <= 2'h0;
         pol_ff <= 1'b0;
      end else if (ce_in && lcd_slice_clock_tick) begin // [RL12]
         if (slice_ff >= last) begin
            slice_ff <= 2'h0;
            pol_ff <= ~pol_ff; // [RL17] [RL9]
         end else begin
            slice_ff <= slice_ff + 2'h1; // [RL1]
         end
      end
   end

   // next drive levels
   for (genvar c = 0; c < 4; c++) begin : g_com
      assign nxt_com[c] = drive_level(1'b1,
         (bias == lcd_seq_pkg::BIAS_STATIC) || (slice_ff == 2'(c) && 2'(c) <= last), pol_ff, bias); // [RL1] [RL2]
   end

   for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
      logic en;
      if (s < lcd_seq_pkg::SHARED_FIRST) begin : g_ded
         assign en = 1'b1;
      end else begin : g_shr
         localparam int PB = lcd_seq_pkg::PORTSEL_TOP - (s - lcd_seq_pkg::SHARED_FIRST) / 2;
         assign en = port_segment_selector_ff[PB]; // [RL8] [RL15]
      end
      assign nxt_seg[s] = en ? drive_level(1'b0, display_on_bit_ff && mem_ff[s][slice_ff], pol_ff, bias)
                             : lcd_seq_pkg::LVL_GROUND; // [RL4] [RL5] [RL14]

      always_ff @(posedge clk_in) begin
         if (!rstn_in) begin
            seg_enable_out[s] <= 1'b0;
         end else if (ce_in) begin
            seg_enable_out[s] <= en; // [RL8]
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         common_drive_out <= '0;
         seg_drive_out <= '0;
      end else if (ce_in) begin
         common_drive_out <= nxt_com;
         seg_drive_out <= nxt_seg;
      end
   end

   property p_slice_advance;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (lcd_slice_clock_tick && slice_ff < last) |=> (slice_ff == $past(slice_ff) + 2'h1);
   endproperty
   a_slice_advance: assert property (p_slice_advance) else $error("slice did not advance"); // [RL1]

   property p_frame_flip;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (lcd_slice_clock_tick && slice_ff >= last) |=> (slice_ff == 2'h0 && pol_ff != $past(pol_ff));
   endproperty
   a_frame_flip: assert property (p_frame_flip) else $error("frame end without polarity flip"); // [RL17]

   property p_pol_hold;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      !lcd_slice_clock_tick |=> ($stable(pol_ff) && $stable(slice_ff));
   endproperty
   a_pol_hold: assert property (p_pol_hold) else $error("slice moved without slice clock"); // [RL12]

   property p_static_same;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (display_mode_reg_ff == lcd_seq_pkg::MODE_STATIC) |=>
         (common_drive_out[0] == common_drive_out[1] && common_drive_out[1] == common_drive_out[2] &&
          common_drive_out[2] == common_drive_out[3]);
   endproperty
   a_static_same: assert property (p_static_same) else $error("static commons differ"); // [RL2]

   property p_seg_select;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (display_on_bit_ff && mem_ff[0][slice_ff]) |=>
         (seg_drive_out[0] == ($past(pol_ff) ? lcd_seq_pkg::LVL_TOP : lcd_seq_pkg::LVL_GROUND));
   endproperty
   a_seg_select: assert property (p_seg_select) else $error("segment select level wrong"); // [RL5]

   property p_display_off;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (!display_on_bit_ff && bias == lcd_seq_pkg::BIAS_THIRD) |=>
         (seg_drive_out[0] == lcd_seq_pkg::LVL_UPPER_MID || seg_drive_out[0] == lcd_seq_pkg::LVL_LOWER_MID);
   endproperty
   a_display_off: assert property (p_display_off) else $error("segment selected while off"); // [RL14]

   property p_half_idle_com;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (display_mode_reg_ff == lcd_seq_pkg::MODE_2S_HALF) |=> (common_drive_out[3] == lcd_seq_pkg::LVL_UPPER_MID);
   endproperty
   a_half_idle_com: assert property (p_half_idle_com) else $error("half bias deselect level wrong"); // [RL11]

   property p_active_com;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (display_mode_reg_ff == lcd_seq_pkg::MODE_4S_THIRD) |=>
         (common_drive_out[$past(slice_ff)] == ($past(pol_ff) ? lcd_seq_pkg::LVL_GROUND : lcd_seq_pkg::LVL_TOP));
   endproperty
   a_active_com: assert property (p_active_com) else $error("active common not at select"); // [RL10]

   property p_upper_zero;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      (setup && !apb_req_in.pwrite && sel == lcd_seq_pkg::SEL_MEM) |=>
         (prdata_ff[31:4] == 28'h0000000 && !pslverr_ff);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("memory upper bits not zero"); // [RL7]

   property p_shared_sel;
      @(posedge clk_in) disable iff (!rstn_in || !ce_in)
      1'b1 |=> (seg_enable_out[lcd_seq_pkg::SHARED_FIRST] == $past(port_segment_selector_ff[lcd_seq_pkg::PORTSEL_TOP]));
   endproperty
   a_shared_sel: assert property (p_shared_sel) else $error("shared pin enable wrong"); // [RL8]
endmodule

// file: lcd_seq_pkg.sv
package lcd_seq_pkg;
   // register byte offsets
   localparam logic [17:0] MODE_OFS = 18'h00000;
   localparam logic [17:0] PORTSEL_OFS = 18'h00004;
   localparam logic [17:0] CLKCFG_OFS = 18'h00008;
   localparam logic [17:0] STATUS_OFS = 18'h0000c;
   // display memory word indices, byte address is four times the index
   localparam logic [15:0] MEM_FIRST_IDX = 16'hfa00;
   localparam logic [15:0] MEM_LAST_IDX = 16'hfa1b;
   // field positions
   localparam int DISP_ON_POS = 7;
   localparam int STAT_POL_POS = 2;
   localparam int SHARED_FIRST = 16;
   localparam int PORTSEL_TOP = 5;
   // reset values
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [5:0] PORTSEL_RST = 6'h00;
   localparam logic [3:0] CLKCFG_RST = 4'h0;
   // display modes
   localparam logic [2:0] MODE_4S_THIRD = 3'h0;
   localparam logic [2:0] MODE_3S_THIRD = 3'h1;
   localparam logic [2:0] MODE_2S_HALF = 3'h2;
   localparam logic [2:0] MODE_3S_HALF = 3'h3;
   localparam logic [2:0] MODE_STATIC = 3'h4;
   // drive level selections
   localparam logic [1:0] LVL_GROUND = 2'h0;
   localparam logic [1:0] LVL_LOWER_MID = 2'h1;
   localparam logic [1:0] LVL_UPPER_MID = 2'h2;
   localparam logic [1:0] LVL_TOP = 2'h3;
   // clock divider counts (log2)
   localparam int SRC_SLOW_LOG2 = 7;
   localparam int SRC_MID_LOG2 = 5;
   localparam int SRC_FAST_LOG2 = 3;
   localparam int SLICE_DIV_BASE_LOG2 = 6;
   localparam int DIV_W = 9;

   typedef enum {BIAS_STATIC, BIAS_HALF, BIAS_THIRD} bias_t;
   typedef enum {SEL_MODE, SEL_PORTSEL, SEL_CLKCFG, SEL_STATUS, SEL_MEM, SEL_NONE} sel_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [17:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage

// file: lcd_slice_clock_gen.sv
`timescale 1ns/1ps
module lcd_slice_clock_gen (
   // clock and control
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // configuration
   input wire logic [1:0] src_sel_in,
   input wire logic [1:0] div_sel_in,
   // subsystem clock pin
   input wire logic sub_clk_in,
   // one pulse per slice
   output logic slice_tick_out
);
   logic sub_meta_ff;
   logic sub_sync_ff;
   logic sub_prev_ff;
   logic [lcd_seq_pkg::SRC_SLOW_LOG2-1:0] pre_ff;
   logic [lcd_seq_pkg::DIV_W-1:0] div_ff;
   logic src_tick;
   logic [lcd_seq_pkg::DIV_W-1:0] mask;

   // two-stage sync plus edge history
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         sub_meta_ff <= 1'b0;
         sub_sync_ff <= 1'b0;
         sub_prev_ff <= 1'b0;
      end else if (ce_in) begin
         sub_meta_ff <= sub_clk_in;
         sub_sync_ff <= sub_meta_ff;
         sub_prev_ff <= sub_sync_ff;
      end
   end

   // source clock selection
   always_comb begin
      case (src_sel_in)
         2'h0: src_tick = &pre_ff[lcd_seq_pkg::SRC_SLOW_LOG2-1:0];
         2'h1: src_tick = sub_sync_ff & ~sub_prev_ff;
         2'h2: src_tick = &pre_ff[lcd_seq_pkg::SRC_MID_LOG2-1:0];
         default: src_tick = &pre_ff[lcd_seq_pkg::SRC_FAST_LOG2-1:0];
      endcase
   end

   // power-of-two slice divider [RL16]
   assign mask = lcd_seq_pkg::DIV_W'((1 << (lcd_seq_pkg::SLICE_DIV_BASE_LOG2 + int'(div_sel_in))) - 1);
   assign slice_tick_out = src_tick && ((div_ff & mask) == mask);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         pre_ff <= '0;
         div_ff <= '0;
      end else if (ce_in) begin
         pre_ff <= pre_ff + 1'b1;
         if (src_tick) begin
            div_ff <= div_ff + 1'b1;
         end
      end
   end
endmodule

// file: lcd_panel_model.sv
`timescale 1ns/1ps
module lcd_panel_model #(
   parameter int NUM_SEG = 28
) (
   // drive levels from the sequencer
   input wire logic [3:0][1:0] common_level_in,
   input wire logic [NUM_SEG-1:0][1:0] seg_level_in,
   // pixel state seen by the glass
   output logic [3:0][NUM_SEG-1:0] pixel_on_out
);
   int diff;

   // level codes map to evenly spaced voltages, full swing is three steps
   always_comb begin
      diff = 0;
      for (int c = 0; c < 4; c++) begin
         for (int n = 0; n < NUM_SEG; n++) begin
            diff = int'(common_level_in[c]) - int'(seg_level_in[n]);
            pixel_on_out[c][n] = (diff == 3) || (diff == -3);
         end
      end
   end
endmodule

// file: test_lcd_common_segment_sequencer.sv
`timescale 1ns/1ps
module test_lcd_common_segment_sequencer;
   localparam int M_4 = lcd_seq_pkg::MODE_4S_THIRD;
   localparam int M_3T = lcd_seq_pkg::MODE_3S_THIRD;
   localparam int M_2H = lcd_seq_pkg::MODE_2S_HALF;
   localparam int M_3H = lcd_seq_pkg::MODE_3S_HALF;
   localparam int M_ST = lcd_seq_pkg::MODE_STATIC;
   localparam int PERIOD = (1 << lcd_seq_pkg::SRC_FAST_LOG2) << lcd_seq_pkg::SLICE_DIV_BASE_LOG2;
   localparam int PERIOD2 = (1 << lcd_seq_pkg::SRC_MID_LOG2) << (lcd_seq_pkg::SLICE_DIV_BASE_LOG2 + 1);
   logic clk_in = 1'b0;
   logic ce = 1'b1;
   logic rstn_in = 1'b0;
   lcd_seq_pkg::apb_req_t req = '0;
   lcd_seq_pkg::apb_rsp_t rsp;
   logic [3:0][1:0] com;
   logic [27:0][1:0] seg;
   logic [27:0] en;
   logic [3:0][27:0] px;
   logic [3:0] mem [28];
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int modes [7] = '{M_4, M_3T, M_2H, M_3H, M_ST, M_4, M_ST};
   logic ons [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   lcd_common_segment_sequencer #(.NUM_SEG(28)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
      .apb_req_in(req), .apb_rsp_out(rsp), .sub_clk_in(1'b0), .common_drive_out(com),
      .seg_drive_out(seg), .seg_enable_out(en));
   lcd_panel_model #(.NUM_SEG(28)) panel (.common_level_in(com), .seg_level_in(seg), .pixel_on_out(px));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      @(posedge clk_in);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_in);
      req.penable <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      #1;
   endtask

   function automatic logic [17:0] mem_addr(input int n);
      return 18'(4 * (int'(lcd_seq_pkg::MEM_FIRST_IDX) + n));
   endfunction

   function automatic logic [1:0] exp_com(input int m, input logic p, input int s, input int c);
      if (m == M_ST || c == s) return p ? lcd_seq_pkg::LVL_GROUND : lcd_seq_pkg::LVL_TOP;
      if (m == M_2H || m == M_3H) return lcd_seq_pkg::LVL_UPPER_MID;
      return p ? lcd_seq_pkg::LVL_UPPER_MID : lcd_seq_pkg::LVL_LOWER_MID;
   endfunction

   function automatic logic [1:0] exp_seg(input int m, input logic on, input logic p, input logic d);
      if (on && d) return p ? lcd_seq_pkg::LVL_TOP : lcd_seq_pkg::LVL_GROUND;
      if (m == M_4 || m == M_3T) return p ? lcd_seq_pkg::LVL_LOWER_MID : lcd_seq_pkg::LVL_UPPER_MID;
      return p ? lcd_seq_pkg::LVL_GROUND : lcd_seq_pkg::LVL_TOP;
   endfunction

   task automatic wait_change(output int t);
      logic [3:0][1:0] old;
      int i;
      old = com;
      i = 0;
      while (com === old && i < 5000) begin
         @(posedge clk_in);
         #1;
         i++;
      end
      chk("slice change", 32'h1, 32'(i < 5000));
      t = cyc;
   endtask

   // read the slice state, then compare every drive level against it
   task automatic observe(input int m, input logic on, output int s, output logic p);
      logic act;
      apb(1'b0, lcd_seq_pkg::STATUS_OFS, '0);
      s = int'(rd[1:0]);
      p = rd[lcd_seq_pkg::STAT_POL_POS];
      for (int c = 0; c < 4; c++) begin
         chk("common level", 32'(exp_com(m, p, s, c)), 32'(com[c]));
         for (int n = 0; n < 28; n++) begin
            act = (n < lcd_seq_pkg::SHARED_FIRST) || en[n];
            if (act) chk("pixel", 32'(on && mem[n][s] && (m == M_ST || c == s)), 32'(px[c][n]));
         end
      end
      for (int n = 0; n < 28; n++) begin
         act = (n < lcd_seq_pkg::SHARED_FIRST) || en[n];
         chk("segment level", act ? 32'(exp_seg(m, on, p, mem[n][s])) : 32'h0, 32'(seg[n]));
      end
   endtask

   initial begin
      int m, n, s, ps, t, t0, per;
      logic on, p, pp;
      logic [3:0][1:0] oc;
      logic [15:0][1:0] os;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      #1;
      for (int c = 0; c < 4; c++) chk("reset common", (c == 0) ? 32'h3 : 32'h1, 32'(com[c]));
      for (int k = 0; k < 28; k++) begin
         chk("reset segment", (k < 16) ? 32'h2 : 32'h0, 32'(seg[k]));
         chk("reset enable", 32'(k < 16), 32'(en[k]));
      end
      apb(1'b0, lcd_seq_pkg::MODE_OFS, '0);
      chk("mode reset", 32'h0, rd);
      apb(1'b0, lcd_seq_pkg::PORTSEL_OFS, '0);
      chk("port selector reset", 32'h0, rd);
      apb(1'b0, lcd_seq_pkg::CLKCFG_OFS, '0);
      chk("clock config reset", 32'h0, rd);
      apb(1'b0, 18'h00010, '0);
      chk("unmapped error", 32'h1, 32'(err));
      apb(1'b0, mem_addr(28), '0);
      chk("past memory error", 32'h1, 32'(err));
      for (int k = 0; k < 28; k++) begin
         mem[k] = 4'(k * 5 + 3);
         apb(1'b1, mem_addr(k), {28'hfffffff, mem[k]});
      end
      for (int k = 0; k < 28; k++) begin
         apb(1'b0, mem_addr(k), '0);
         chk("display memory", {28'h0, mem[k]}, rd);
      end
      apb(1'b1, lcd_seq_pkg::PORTSEL_OFS, 32'h21);
      apb(1'b0, lcd_seq_pkg::PORTSEL_OFS, '0);
      chk("port selector", 32'h21, rd);
      apb(1'b1, lcd_seq_pkg::CLKCFG_OFS, 32'hc);
      apb(1'b0, lcd_seq_pkg::CLKCFG_OFS, '0);
      chk("clock config", 32'hc, rd);
      apb(1'b1, lcd_seq_pkg::MODE_OFS, 32'h85);
      apb(1'b0, lcd_seq_pkg::MODE_OFS, '0);
      chk("prohibited mode", 32'h80, rd);
      for (int k = 0; k < 7; k++) begin
         m = modes[k];
         on = ons[k];
         n = (m == M_4) ? 4 : (m == M_2H) ? 2 : (m == M_ST) ? 1 : 3;
         per = (k == 6) ? PERIOD2 : PERIOD;
         if (k == 6) apb(1'b1, lcd_seq_pkg::CLKCFG_OFS, 32'h9);
         apb(1'b1, lcd_seq_pkg::MODE_OFS, {24'h0, on, 4'h0, 3'(m)});
         apb(1'b0, lcd_seq_pkg::MODE_OFS, '0);
         chk("mode", {24'h0, on, 4'h0, 3'(m)}, rd);
         wait_change(t0);
         for (int j = 0; j < 2 * n + 2; j++) begin
            wait_change(t);
            observe(m, on, s, p);
            if (j > 0) begin
               chk("slice period", 32'(per), 32'(t - t0));
               chk("slice order", 32'((ps + 1) % n), 32'(s));
               chk("polarity", 32'((s == 0) ? !pp : pp), 32'(p));
            end
            t0 = t;
            ps = s;
            pp = p;
         end
      end
      // clock enable low must freeze sequencing and drive levels
      @(posedge clk_in);
      ce <= 1'b0;
      #1;
      oc = com;
      os = seg[15:0];
      repeat (4200) @(posedge clk_in);
      ce <= 1'b1;
      #1;
      chk("frozen commons", 32'(oc), 32'(com));
      chk("frozen segments", 32'(os), 32'(seg[15:0]));
      report_and_stop;
   end

   initial begin
      repeat (100000) @(posedge clk_in);
      bad_count++;
      report_and_stop;
   end
endmodule
